// *** rtl/cir_consts.svh ***
// constants for the consumer infrared modulation and configuration block
`ifndef CIR_CONSTS_SVH
`define CIR_CONSTS_SVH

// ------------------------------------------------------------------
// clock rate
// ------------------------------------------------------------------
`define CIR_CLK_KHZ 25000
`define CIR_CLK_MHZ 25
`define CIR_NS_PER_US 1000

// ------------------------------------------------------------------
// register word indexes (byte address is four times the index)
// ------------------------------------------------------------------
`define CIR_IDX_DEMOD 4'h0
`define CIR_IDX_TXMOD 4'h1
`define CIR_IDX_CIRCFG 4'h2
`define CIR_IDX_LINECTL 4'h3
`define CIR_IDX_IDCTL1 4'h4
`define CIR_IDX_CFG3 4'h6
`define CIR_IDX_CFG4 4'h7
`define CIR_IDX_IRMODE 4'h8
`define CIR_IDX_TXDATA 4'h9
`define CIR_IDX_STATUS 4'ha

// ------------------------------------------------------------------
// reset values and writable masks
// ------------------------------------------------------------------
`define CIR_RST_DEMOD 8'h29
`define CIR_RST_TXMOD 8'h69
`define CIR_RST_ZERO 8'h00
`define CIR_MASK_CIRCFG 8'hf7
`define CIR_MASK_CFG3 8'h77
`define CIR_MASK_CFG4 8'hb8

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define CIR_CFG_TXHI 2
`define CIR_CFG_DMDIS 4
`define CIR_CFG_RXHI 5
`define CIR_CFG_OVS 6
`define CIR_CFG_RLEN 7
`define CIR_CFG4_HIDIR 3
`define CIR_CFG4_RXINV 4
`define CIR_CFG4_S0DIR 5
`define CIR_CFG4_AUTO 7

// ------------------------------------------------------------------
// burst sizes and byte framing
// ------------------------------------------------------------------
`define CIR_BURST_EIGHT 4'h8
`define CIR_BURST_SIX 4'h6
`define CIR_BYTE_BITS 8'h08

`endif

// *** rtl/cir_pkg.sv ***
// types for the consumer infrared modulation and configuration block
package cir_pkg;

    // ------------------------------------------------------------------
    // modes
    // ------------------------------------------------------------------
    // link mode of the serial port, chosen by software
    typedef enum logic [1:0] {
        CIR_MODE_UART,
        CIR_MODE_SHARP,
        CIR_MODE_CONSUMER,
        CIR_MODE_RSVD
    } cir_ir_mode_t;

    // ------------------------------------------------------------------
    // transceiver pin bundles
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rxIn;
        logic sel0In;
        logic [1:0] selHiIn;
        logic id3In;
    } cir_xcvr_in_t;

    typedef struct packed {
        logic irTx;
        logic sel0Out;
        logic sel0Oe;
        logic [1:0] selHiOut;
        logic selHiOe;
    } cir_xcvr_out_t;

    // ------------------------------------------------------------------
    // whole state of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] demodCtl;
        logic [7:0] txModCtl;
        logic [7:0] cirCfg;
        logic [7:0] lineCtl;
        logic [7:0] cfg3;
        logic [7:0] cfg4;
        logic [2:0] idCtl;
        cir_ir_mode_t irMode;
        logic ack;
        logic [7:0] rdData;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] sync3;
        logic [4:0] pinStable;
        logic [7:0] txShift;
        logic [7:0] bitsLeft;
        logic curBit;
        logic [15:0] carCnt;
        logic [3:0] pulsesLeft;
        logic irTx;
        logic [15:0] edgeCnt;
        logic [16:0] holdCnt;
        logic prevLvl;
        logic rxBit;
        logic [2:0] selOut;
    } cir_state_t;

endpackage

// *** rtl/cir_modulation_config.sv ***
// consumer infrared modulator, demodulator and transceiver pin control
`timescale 1ns/1ns
`include "cir_consts.svh"

module cir_modulation_config (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // bit timing from the serial core
    input wire logic bitTick,
    // transceiver pins
    input wire cir_pkg::cir_xcvr_in_t xcvrIn,
    output cir_pkg::cir_xcvr_out_t xcvrOut,
    // received data and shared line control
    output logic rxBit,
    output logic demodOut,
    output logic [7:0] lineControl
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // carrier period in clocks for a frequency code, zero when reserved
    function automatic logic [15:0] cirPeriod(input logic [4:0] code,
                                              input logic hi);
        int khz10;
        khz10 = 0;
        if (hi) begin
            case (code)
                5'h03: khz10 = 4000;
                5'h08: khz10 = 4500;
                5'h0b: khz10 = 4800;
                default: khz10 = 0;
            endcase
        end else if (code >= 5'h03 && code <= 5'h0e) begin
            khz10 = 300 + 10 * (int'(code) - 3);
        end else begin
            case (code)
                5'h1a: khz10 = 530;
                5'h1b: khz10 = 540;
                5'h1c: khz10 = 550;
                5'h1d: khz10 = 560;
                5'h1e: khz10 = 569;
                default: khz10 = 0;
            endcase
        end
        if (khz10 == 0) begin
            cirPeriod = 16'h0000;
        end else begin
            cirPeriod = 16'((`CIR_CLK_KHZ * 10) / khz10);
        end
    endfunction

    // carrier high time in clocks for a width code, zero when reserved
    function automatic logic [15:0] cirWidth(input logic [2:0] code,
                                             input logic hi);
        int ns;
        ns = 0;
        case ({hi, code})
            4'h2: ns = 6000;
            4'h3: ns = 7000;
            4'h4: ns = 9000;
            4'h5: ns = 10600;
            4'ha: ns = 700;
            4'hb: ns = 800;
            4'hc: ns = 900;
            default: ns = 0;
        endcase
        cirWidth = 16'((ns * `CIR_CLK_MHZ) / `CIR_NS_PER_US);
    endfunction

    // ------------------------------------------------------------------
    // state and working signals
    // ------------------------------------------------------------------
    cir_pkg::cir_state_t s_reg; // registered state
    cir_pkg::cir_state_t s_next; // next state
    logic busReq; // new request this cycle
    logic [3:0] regIdx; // word index of the access
    logic [7:0] wrByte; // low write lane
    logic [7:0] rdByte; // read mux result
    logic autoCfg; // pins follow mode values
    logic sel0Dir; // pin 0 is output
    logic selHiDir; // upper pins are output
    logic runLen; // run-length coding on
    logic [1:0] modMode; // modulation mode field
    logic [15:0] txPeriod; // carrier period in clocks
    logic [15:0] txWidth; // carrier high time in clocks
    logic newBit; // bit presented after this tick
    logic startRun; // a zero run begins
    logic carOn; // carrier running now
    logic rxLvl; // receive level after inversion
    logic [15:0] rxCenter; // expected period in clocks
    logic [18:0] rxTolWide; // center times bandwidth
    logic [15:0] rxTol; // accepted deviation
    logic rxFall; // start of a received pulse
    logic rxDemod; // demodulated or bypassed level

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------

    // one combinational pass over bus, transmitter, receiver and pins
    always_comb begin
        s_next = s_reg;
        regIdx = wb_adr_i[5:2];
        wrByte = wb_dat_i[7:0];
        // classic cycle answered one clock after the strobe
        busReq = wb_cyc_i & wb_stb_i & ~s_reg.ack;
        s_next.ack = busReq;
        autoCfg = s_reg.cfg4[`CIR_CFG4_AUTO];
        sel0Dir = s_reg.cfg4[`CIR_CFG4_S0DIR];
        selHiDir = s_reg.cfg4[`CIR_CFG4_HIDIR];
        runLen = s_reg.cirCfg[`CIR_CFG_RLEN];
        modMode = s_reg.cirCfg[1:0];

        // pin synchronisers: change taken once stages two and three agree
        s_next.sync1 = {xcvrIn.id3In, xcvrIn.selHiIn, xcvrIn.sel0In,
                        xcvrIn.rxIn};
        s_next.sync2 = s_reg.sync1;
        s_next.sync3 = s_reg.sync2;
        s_next.pinStable = (s_reg.sync3 & ~(s_reg.sync2 ^ s_reg.sync3)) |
                           (s_reg.pinStable & (s_reg.sync2 ^ s_reg.sync3));

        // read mux, unmapped words read zero
        rdByte = 8'h00;
        if (regIdx == `CIR_IDX_DEMOD) begin
            rdByte = s_reg.demodCtl;
        end else if (regIdx == `CIR_IDX_TXMOD) begin
            rdByte = s_reg.txModCtl;
        end else if (regIdx == `CIR_IDX_CIRCFG) begin
            rdByte = s_reg.cirCfg;
        end else if (regIdx == `CIR_IDX_LINECTL) begin
            rdByte = s_reg.lineCtl;
        end else if (regIdx == `CIR_IDX_IDCTL1) begin
            rdByte[3] = s_reg.pinStable[4];
            // written values when driving, live pins when sensing
            rdByte[2:1] = selHiDir ? s_reg.idCtl[2:1]
                                   : s_reg.pinStable[3:2];
            rdByte[0] = sel0Dir ? s_reg.idCtl[0]
                                : s_reg.pinStable[1];
        end else if (regIdx == `CIR_IDX_CFG3) begin
            rdByte = s_reg.cfg3;
        end else if (regIdx == `CIR_IDX_CFG4) begin
            rdByte = s_reg.cfg4;
        end else if (regIdx == `CIR_IDX_IRMODE) begin
            rdByte = {6'h00, s_reg.irMode};
        end else if (regIdx == `CIR_IDX_STATUS) begin
            rdByte = {5'h00, (s_reg.bitsLeft != 8'h00),
                      (s_reg.holdCnt != 17'h00000), s_reg.rxBit};
        end else begin
            rdByte = 8'h00;
        end
        // read data captured with the request, held until the next
        if (busReq && !wb_we_i) begin
            s_next.rdData = rdByte;
        end

        // transmit bit sequencing on the serial bit tick
        newBit = s_reg.curBit;
        if (bitTick) begin
            if (s_reg.bitsLeft != 8'h00) begin
                // run-length bytes hold the value in the top bit
                newBit = runLen ? s_reg.txShift[7]
                                : s_reg.txShift[0];
                if (!runLen) begin
                    s_next.txShift = {1'b0, s_reg.txShift[7:1]};
                end
                s_next.bitsLeft = s_reg.bitsLeft - 8'h01;
            end else begin
                // idle line is a logic one
                newBit = 1'b1;
            end
        end
        s_next.curBit = newBit;
        startRun = bitTick & s_reg.curBit & ~newBit;

        // register writes on the low lane
        if (busReq && wb_we_i && wb_sel_i[0]) begin
            if (regIdx == `CIR_IDX_DEMOD) begin
                s_next.demodCtl = wrByte;
            end else if (regIdx == `CIR_IDX_TXMOD) begin
                s_next.txModCtl = wrByte;
            end else if (regIdx == `CIR_IDX_CIRCFG) begin
                s_next.cirCfg = wrByte & `CIR_MASK_CIRCFG;
            end else if (regIdx == `CIR_IDX_LINECTL) begin
                s_next.lineCtl = wrByte;
            end else if (regIdx == `CIR_IDX_IDCTL1) begin
                // bits whose pins are inputs keep their old value
                if (sel0Dir) begin
                    s_next.idCtl[0] = wrByte[0];
                end
                if (selHiDir) begin
                    s_next.idCtl[2:1] = wrByte[2:1];
                end
            end else if (regIdx == `CIR_IDX_CFG3) begin
                s_next.cfg3 = wrByte & `CIR_MASK_CFG3;
            end else if (regIdx == `CIR_IDX_CFG4) begin
                s_next.cfg4 = wrByte & `CIR_MASK_CFG4;
            end else if (regIdx == `CIR_IDX_IRMODE) begin
                s_next.irMode = cir_pkg::cir_ir_mode_t'(wrByte[1:0]);
            end else if (regIdx == `CIR_IDX_TXDATA) begin
                // a byte is taken only while the shifter is empty
                if (s_reg.bitsLeft == 8'h00) begin
                    s_next.txShift = wrByte;
                    if (runLen) begin
                        // run of one to one hundred twenty-eight bits
                        s_next.bitsLeft = {1'b0, wrByte[6:0]} +
                                          8'h01;
                    end else begin
                        s_next.bitsLeft = `CIR_BYTE_BITS;
                    end
                end
            end else begin
                // unmapped write is acknowledged and dropped
                s_next.ack = busReq;
            end
        end

        // carrier timing from the modulator codes and range bit
        txPeriod = cirPeriod(s_reg.txModCtl[4:0],
                             s_reg.cirCfg[`CIR_CFG_TXHI]);
        txWidth = cirWidth(s_reg.txModCtl[7:5],
                           s_reg.cirCfg[`CIR_CFG_TXHI]);

        // carrier gating per modulation mode, reserved mode stays dark
        case (modMode)
            2'b00: carOn = ~s_reg.curBit;
            2'b01: carOn = s_reg.pulsesLeft != 4'h0;
            2'b10: carOn = s_reg.pulsesLeft != 4'h0;
            default: carOn = 1'b0;
        endcase
        carOn = carOn && (txPeriod != 16'h0000) &&
                (s_reg.irMode == cir_pkg::CIR_MODE_CONSUMER);

        if (startRun) begin
            // every new zero run starts the carrier phase afresh
            s_next.carCnt = 16'h0000;
            case (modMode)
                2'b01: s_next.pulsesLeft = `CIR_BURST_EIGHT;
                2'b10: s_next.pulsesLeft = `CIR_BURST_SIX;
                default: s_next.pulsesLeft = 4'h0;
            endcase
        end else if (carOn) begin
            if (s_reg.carCnt >= txPeriod - 16'h0001) begin
                // period wrap ends one pulse of a burst
                s_next.carCnt = 16'h0000;
                if (s_reg.pulsesLeft != 4'h0) begin
                    s_next.pulsesLeft = s_reg.pulsesLeft - 4'h1;
                end
            end else begin
                s_next.carCnt = s_reg.carCnt + 16'h0001;
            end
        end else begin
            s_next.carCnt = 16'h0000;
            s_next.pulsesLeft = 4'h0;
        end
        // high for the pulse width at the start of each period
        s_next.irTx = carOn && (s_reg.carCnt < txWidth);

        // receive path: optional inversion, pulses are low levels
        rxLvl = s_reg.pinStable[0] ^ s_reg.cfg4[`CIR_CFG4_RXINV];
        s_next.prevLvl = rxLvl;
        rxFall = s_reg.prevLvl & ~rxLvl;
        rxCenter = cirPeriod(s_reg.demodCtl[4:0],
                             s_reg.cirCfg[`CIR_CFG_RXHI]);
        rxTolWide = {3'h0, rxCenter} * {16'h0000, s_reg.demodCtl[7:5]};
        rxTol = {1'b0, rxTolWide[18:4]};

        // period between pulse starts, saturating
        if (rxFall) begin
            s_next.edgeCnt = 16'h0000;
        end else if (s_reg.edgeCnt != 16'hffff) begin
            s_next.edgeCnt = s_reg.edgeCnt + 16'h0001;
        end

        // envelope holds two periods past the last accepted pulse
        if (rxFall && (rxCenter != 16'h0000) &&
            (s_reg.edgeCnt + rxTol >= rxCenter) &&
            (s_reg.edgeCnt <= rxCenter + rxTol)) begin
            s_next.holdCnt = {rxCenter, 1'b0};
        end else if (s_reg.holdCnt != 17'h00000) begin
            s_next.holdCnt = s_reg.holdCnt - 17'h00001;
        end

        // carrier present reads as a logic zero bit
        rxDemod = s_reg.cirCfg[`CIR_CFG_DMDIS] ? rxLvl
                  : (s_reg.holdCnt == 17'h00000);

        // sample at the bit tick or follow every clock
        if (s_reg.cirCfg[`CIR_CFG_OVS]) begin
            s_next.rxBit = rxDemod;
        end else if (bitTick) begin
            s_next.rxBit = rxDemod;
        end

        // selection pin values: direct control or per-mode values
        if (!autoCfg) begin
            s_next.selOut = s_reg.idCtl;
        end else begin
            case (s_reg.irMode)
                cir_pkg::CIR_MODE_SHARP: s_next.selOut = s_reg.idCtl;
                cir_pkg::CIR_MODE_CONSUMER: begin
                    // range of the receiver picks the stored set
                    s_next.selOut = s_reg.cirCfg[`CIR_CFG_RXHI] ?
                                    s_reg.cfg3[6:4] :
                                    s_reg.cfg3[2:0];
                end
                default: s_next.selOut = 3'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------

    // every field takes a constant under reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.demodCtl <= `CIR_RST_DEMOD;
            s_reg.txModCtl <= `CIR_RST_TXMOD;
            s_reg.cirCfg <= `CIR_RST_ZERO;
            s_reg.cfg3 <= `CIR_RST_ZERO;
            s_reg.cfg4 <= `CIR_RST_ZERO;
            s_reg.irMode <= cir_pkg::CIR_MODE_UART;
            s_reg.curBit <= 1'b1;
            s_reg.prevLvl <= 1'b1;
            s_reg.rxBit <= 1'b1;
            s_reg.sync1 <= 5'h1f;
            s_reg.sync2 <= 5'h1f;
            s_reg.sync3 <= 5'h1f;
            s_reg.pinStable <= 5'h1f;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------

    // bus answer
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = {24'h000000, s_reg.rdData};

    // transceiver pins, enables follow the direction bits
    assign xcvrOut.irTx = s_reg.irTx;
    assign xcvrOut.sel0Out = s_reg.selOut[0];
    assign xcvrOut.sel0Oe = s_reg.cfg4[`CIR_CFG4_S0DIR];
    assign xcvrOut.selHiOut = s_reg.selOut[2:1];
    assign xcvrOut.selHiOe = s_reg.cfg4[`CIR_CFG4_HIDIR];

    // receive data and shared line control storage
    assign rxBit = s_reg.rxBit;
    assign demodOut = s_reg.holdCnt == 17'h00000;
    assign lineControl = s_reg.lineCtl;

endmodule // cir_modulation_config

// *** tb/cir_checker.sv ***
// assertion checker for the consumer infrared block
`timescale 1ns/1ns
module cir_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins and shared line control
    input wire cir_pkg::cir_xcvr_out_t xcvrOut,
    input wire logic [7:0] lineControl
);
    // ------------------------------------------------------------------
    // bus answer and pin relations
    // ------------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    dat_hold_a: assert property ($changed(wb_dat_o)
        |-> wb_ack_o && !$past(wb_we_i)) else $error("read data moved");
    line_write_a: assert property ($changed(lineControl) |-> wb_ack_o
        && $past(wb_we_i) && $past(wb_adr_i[5:2]) == 4'h3)
        else $error("line control moved without write");
    sel0_dir_a: assert property ($changed(xcvrOut.sel0Oe) |-> wb_ack_o
        && $past(wb_adr_i[5:2]) == 4'h7) else $error("pin 0 direction");
    hi_dir_a: assert property ($changed(xcvrOut.selHiOe) |-> wb_ack_o
        && $past(wb_adr_i[5:2]) == 4'h7) else $error("upper direction");
    sel_drive_a: assert property ($changed({xcvrOut.sel0Out,
        xcvrOut.selHiOut}) |-> wb_ack_o || $past(wb_ack_o))
        else $error("selection pins moved without write");
    tx_pulse_a: assert property ($rose(xcvrOut.irTx)
        |-> xcvrOut.irTx[*8]) else $error("carrier pulse too short");
endmodule // cir_checker

// *** tb/cir_xcvr_model.sv ***
// optical transceiver model on the selection and id pins
`timescale 1ns/1ns
module cir_xcvr_model (
    // pins from the block
    input wire cir_pkg::cir_xcvr_out_t xcvrOut,
    // identification levels the adaptor reports
    input wire logic [3:0] idLevel,
    // receiver output level from the bench
    input wire logic rxLevel,
    // pins into the block
    output cir_pkg::cir_xcvr_in_t xcvrIn
);
    // wire level: block drives when enabled, else adaptor id level
    always_comb begin
        xcvrIn.rxIn = rxLevel; // idles high with no light
        xcvrIn.sel0In = xcvrOut.sel0Oe ? xcvrOut.sel0Out : idLevel[0];
        xcvrIn.selHiIn = xcvrOut.selHiOe ? xcvrOut.selHiOut : idLevel[2:1];
        xcvrIn.id3In = idLevel[3];
    end
endmodule // cir_xcvr_model

// *** tb/testbench.sv ***
// register and carrier tests for the consumer infrared block
`timescale 1ns/1ns
module testbench;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, bitTick;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i, idLevel;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0] lineControl, q;
    logic rxBit, demodOut, rxLevel;
    cir_pkg::cir_xcvr_in_t xcvrIn;
    cir_pkg::cir_xcvr_out_t xcvrOut;
    int badCount, checkCount;
    // clock of 40 ns
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    cir_modulation_config i_cir_modulation_config (.clk_sys(clk_sys),
        .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .bitTick(bitTick), .xcvrIn(xcvrIn), .xcvrOut(xcvrOut),
        .rxBit(rxBit), .demodOut(demodOut), .lineControl(lineControl));
    cir_xcvr_model i_cir_xcvr_model (.xcvrOut(xcvrOut),
        .idLevel(idLevel), .rxLevel(rxLevel), .xcvrIn(xcvrIn));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task tallyAndFinish;
        if (badCount == 0 && checkCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one classic cycle, held until ack is sampled
    task bus(input logic we, input logic [3:0] idx, input logic [7:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    // read and compare
    task rd(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk({24'h0, q}, {24'h0, exp});
    endtask
    // pin bundle: oe0, oeHi, out0, outHi
    function automatic logic [31:0] pins();
        return {27'h0, xcvrOut.sel0Oe, xcvrOut.selHiOe, xcvrOut.sel0Out,
            xcvrOut.selHiOut};
    endfunction
    // send one byte, count carrier rises and first pulse width
    task tx(input logic [7:0] cfg, mod, b, input int rises, width);
        int n, r, w;
        logic prev;
        bus(1'b1, 4'h2, cfg);
        bus(1'b1, 4'h1, mod);
        bus(1'b1, 4'h9, b);
        r = 0;
        w = 0;
        prev = 1'b0;
        for (n = 0; n < 10000; n++) begin
            bitTick <= (n % 1000 == 999);
            @(posedge clk_sys);
            if (xcvrOut.irTx === 1'b1 && !prev) r++;
            if (xcvrOut.irTx === 1'b1 && r == 1) w++;
            prev = (xcvrOut.irTx === 1'b1);
        end
        bitTick <= 1'b0;
        chk(r, rises);
        chk(w, width);
    endtask
    // pulses every per clocks, then check envelope and sampled bit
    task rx(input logic [7:0] cfg, input int per, tk, input logic ed, eb);
        int n;
        bus(1'b1, 4'h2, cfg);
        for (n = 0; n < 3000; n++) begin
            rxLevel <= ((n + 50) % per >= 100);
            bitTick <= (n == tk);
            @(posedge clk_sys);
        end
        rxLevel <= 1'b1;
        bitTick <= 1'b0;
        @(posedge clk_sys);
        chk({31'h0, demodOut}, {31'h0, ed});
        chk({31'h0, rxBit}, {31'h0, eb});
    endtask
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, bitTick} = 4'h0;
        wb_adr_i = 6'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        idLevel = 4'ha;
        rxLevel = 1'b1;
        badCount = 0;
        checkCount = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(4'h2, 8'h00);
        rd(4'h1, 8'h69);
        bus(1'b1, 4'h2, 8'hff);
        rd(4'h2, 8'hf7);
        bus(1'b1, 4'h3, 8'ha5);
        rd(4'h3, 8'ha5);
        chk({24'h0, lineControl}, 32'ha5);
        rd(4'h5, 8'h00);
        rd(4'h4, 8'h0a);
        bus(1'b1, 4'h4, 8'h05);
        rd(4'h4, 8'h0a);
        bus(1'b1, 4'h7, 8'h28);
        bus(1'b1, 4'h4, 8'h05);
        rd(4'h4, 8'h0d);
        chk(pins(), 32'h1e);
        bus(1'b1, 4'h7, 8'ha8);
        bus(1'b1, 4'h8, 8'h00);
        chk(pins(), 32'h18);
        bus(1'b1, 4'h8, 8'h01);
        chk(pins(), 32'h1e);
        bus(1'b1, 4'h6, 8'h63);
        bus(1'b1, 4'h8, 8'h02);
        chk(pins(), 32'h1b);
        bus(1'b1, 4'h2, 8'h00);
        chk(pins(), 32'h1d);
        bus(1'b1, 4'h7, 8'h00);
        bus(1'b1, 4'h8, 8'h02);
        tx(8'h00, 8'h69, 8'hfe, 2, 175);
        tx(8'h01, 8'h69, 8'hfe, 8, 175);
        tx(8'h02, 8'h69, 8'hfe, 6, 175);
        tx(8'h03, 8'h69, 8'hfe, 0, 0);
        tx(8'h05, 8'h43, 8'hfe, 8, 17);
        tx(8'h01, 8'h60, 8'hfe, 0, 0);
        tx(8'h80, 8'h69, 8'h01, 3, 175);
        rx(8'h00, 694, 2999, 1'b0, 1'b0);
        rx(8'h00, 600, 2999, 1'b1, 1'b1);
        rx(8'h20, 694, 2999, 1'b1, 1'b1);
        rx(8'h10, 3000, 2999, 1'b1, 1'b0);
        rx(8'h50, 3000, 0, 1'b1, 1'b0);
        tallyAndFinish();
    end
    // hang guard
    initial begin
        repeat (95000) @(posedge clk_sys);
        badCount++;
        tallyAndFinish();
    end
endmodule // testbench

bind cir_modulation_config cir_checker i_cir_checker (.clk_sys(clk_sys),
    .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .xcvrOut(xcvrOut), .lineControl(lineControl));
